//--- core/pxb_crossbar.sv
// Priority crossbar with its two enable registers, routing peripherals to port pins.
`timescale 1ns/1ps
`include "pxb_defs.svh"

module pxb_crossbar (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register bus.
    input wire pxb_pkg::pxb_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    // Controls held elsewhere on the same clock.
    input wire logic crossbar_global_en_i,
    input wire logic [`PXB_NPIN-1:0] pin_skip_bits_i,
    input wire logic spi_nss_4wire_i,
    // Peripheral side.
    input wire pxb_pkg::pxb_periph_drive_t periph_i,
    output logic [`PXB_NSLOT-1:0] slot_in_o,
    output logic uart_rx_o,
    output logic can_rx_o,
    // Pin side.
    input wire logic [`PXB_NPIN-1:0] pin_in_i,
    output logic [`PXB_NPIN-1:0] pin_out_o,
    output logic [`PXB_NPIN-1:0] pin_oe_o
);

    logic [7:0] route_a_q;
    logic [7:0] route_b_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [`PXB_NPIN-1:0] pin_meta_q;
    logic [`PXB_NPIN-1:0] pin_sync_q;
    logic [`PXB_NSLOT-1:0] slot_en;
    logic [2:0] cnt_field;
    logic [2:0] cnt_routed;
    logic [`PXB_NPIN-1:0] fixed_taken;
    logic [`PXB_NPIN-1:0] map_used;
    logic [4:0] map_sel [`PXB_NPIN];
    logic [`PXB_NSLOT-1:0] slot_has;
    logic [3:0] slot_pin [`PXB_NSLOT];
    logic [`PXB_NPIN-1:0] pin_out_d;
    logic [`PXB_NPIN-1:0] pin_oe_d;
    logic [`PXB_NSLOT-1:0] slot_in_d;
    logic uart_on;
    logic can_on;
    logic hit_a;
    logic hit_b;

    // Address decode of the two registers.
    assign hit_a = (sfr_req_i.addr == `PXB_ADDR_ROUTE_A);
    assign hit_b = (sfr_req_i.addr == `PXB_ADDR_ROUTE_B);

    // Read data; unmapped addresses return zero, the reserved bit 0 reads zero.
    assign rdata_d = !sfr_req_i.rd ? rdata_q :
                     hit_a ? route_a_q :
                     hit_b ? route_b_q :
                     8'h00;

    // Register writes; new values steer the pins from the next cycle on.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            route_a_q <= `PXB_RESET_ROUTE_A;
            route_b_q <= `PXB_RESET_ROUTE_B;
            rdata_q <= 8'h00;
        end else begin
            if (sfr_req_i.wr && hit_a) begin
                route_a_q <= sfr_req_i.wdata;
            end
            if (sfr_req_i.wr && hit_b) begin
                route_b_q <= sfr_req_i.wdata & `PXB_B_WRITABLE;
            end
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_o = rdata_q;

    // Pin levels come from outside the clock domain, so two flip-flops first.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_in_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Module output count; the reserved code 111 is treated like 110.
    assign cnt_field = route_b_q[`PXB_B_CNT_MSB:`PXB_B_CNT_LSB];
    assign cnt_routed = (cnt_field > `PXB_CNT_MAX) ? `PXB_CNT_MAX : cnt_field;

    // Per-slot enables in priority order.
    assign slot_en[`PXB_S_SPI_SCK] = route_a_q[`PXB_A_SERIAL_PERIPH];
    assign slot_en[`PXB_S_SPI_MISO] = route_a_q[`PXB_A_SERIAL_PERIPH];
    assign slot_en[`PXB_S_SPI_MOSI] = route_a_q[`PXB_A_SERIAL_PERIPH];
    assign slot_en[`PXB_S_SPI_NSS] = route_a_q[`PXB_A_SERIAL_PERIPH] & spi_nss_4wire_i;
    assign slot_en[`PXB_S_TW_DATA] = route_a_q[`PXB_A_TWOWIRE];
    assign slot_en[`PXB_S_TW_CLOCK] = route_a_q[`PXB_A_TWOWIRE];
    assign slot_en[`PXB_S_CMP0] = route_a_q[`PXB_A_CMP0_SYNC];
    assign slot_en[`PXB_S_CMP0_ASYNC] = route_a_q[`PXB_A_CMP0_ASYNC];
    assign slot_en[`PXB_S_CMP1] = route_a_q[`PXB_A_CMP1_SYNC];
    assign slot_en[`PXB_S_CMP1_ASYNC] = route_a_q[`PXB_A_CMP1_ASYNC];
    assign slot_en[`PXB_S_SYSCLK] = route_b_q[`PXB_B_SYSCLK];
    assign slot_en[`PXB_S_EXT_IN] = route_b_q[`PXB_B_EXT_IN];
    assign slot_en[`PXB_S_TIMER_A] = route_b_q[`PXB_B_TIMER_A];
    assign slot_en[`PXB_S_TIMER_B] = route_b_q[`PXB_B_TIMER_B];

    // Module outputs always count up from module 0.
    genvar gc;
    generate
        for (gc = 0; gc < 5; gc++) begin : g_cex
            assign slot_en[`PXB_S_MOD_OUT0 + gc] = (cnt_routed > 3'(gc));
        end
    endgenerate

    // UART and CAN pairs sit on their fixed pins, both signals together.
    assign uart_on = route_a_q[`PXB_A_UART];
    assign can_on = route_a_q[`PXB_A_CAN];
    always_comb begin
        fixed_taken = '0;
        fixed_taken[`PXB_PIN_UART_TX] = uart_on;
        fixed_taken[`PXB_PIN_UART_RX] = uart_on;
        fixed_taken[`PXB_PIN_CAN_TX] = can_on;
        fixed_taken[`PXB_PIN_CAN_RX] = can_on;
    end

    // Priority decode: each enabled slot takes the lowest pin still free.
    // This is a long combinational chain; acceptable since it only follows register writes.
    always_comb begin
        logic [`PXB_NPIN-1:0] taken;
        logic found;
        taken = pin_skip_bits_i | fixed_taken;
        found = 1'b0;
        map_used = '0;
        slot_has = '0;
        for (int p = 0; p < `PXB_NPIN; p++) begin
            map_sel[p] = 5'h00;
        end
        for (int s = 0; s < `PXB_NSLOT; s++) begin
            slot_pin[s] = 4'h0;
        end
        for (int s = 0; s < `PXB_NSLOT; s++) begin
            found = 1'b0;
            for (int p = 0; p < `PXB_NPIN; p++) begin
                if (slot_en[s] && !found && !taken[p]) begin
                    taken[p] = 1'b1;
                    found = 1'b1;
                    map_used[p] = 1'b1;
                    map_sel[p] = 5'(s);
                    slot_has[s] = 1'b1;
                    slot_pin[s] = 4'(p);
                end
            end
        end
    end

    // Per-pin drive; every pin stays a plain input until the crossbar is on.
    genvar gp;
    generate
        for (gp = 0; gp < `PXB_NPIN; gp++) begin : g_pin
            logic drv_out;
            logic drv_oe;
            if (gp == `PXB_PIN_UART_TX) begin : g_uart
                assign drv_out = uart_on ? periph_i.uart_tx : periph_i.slot_out[map_sel[gp]];
                assign drv_oe = uart_on | (map_used[gp] & periph_i.slot_oe[map_sel[gp]]);
            end else if (gp == `PXB_PIN_CAN_TX) begin : g_can
                assign drv_out = can_on ? periph_i.can_tx : periph_i.slot_out[map_sel[gp]];
                assign drv_oe = can_on | (map_used[gp] & periph_i.slot_oe[map_sel[gp]]);
            end else begin : g_plain
                assign drv_out = periph_i.slot_out[map_sel[gp]];
                assign drv_oe = map_used[gp] & periph_i.slot_oe[map_sel[gp]];
            end
            assign pin_out_d[gp] = drv_out;
            assign pin_oe_d[gp] = crossbar_global_en_i & drv_oe;
        end
    endgenerate

    // Input levels handed back to each slot; unrouted inputs idle high.
    generate
        for (gc = 0; gc < `PXB_NSLOT; gc++) begin : g_slot_in
            assign slot_in_d[gc] = (crossbar_global_en_i & slot_has[gc]) ?
                                   pin_sync_q[slot_pin[gc]] : 1'b1;
        end
    endgenerate

    // Output flops, so the pins change one cycle after the decode settles.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            slot_in_o <= '1;
            uart_rx_o <= 1'b1;
            can_rx_o <= 1'b1;
        end else begin
            pin_out_o <= pin_out_d;
            pin_oe_o <= pin_oe_d;
            slot_in_o <= slot_in_d;
            uart_rx_o <= (crossbar_global_en_i & uart_on) ? pin_sync_q[`PXB_PIN_UART_RX] : 1'b1;
            can_rx_o <= (crossbar_global_en_i & can_on) ? pin_sync_q[`PXB_PIN_CAN_RX] : 1'b1;
        end
    end

    // Checks on the routing behaviour.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    a_global_gate: assert property (!crossbar_global_en_i |=> pin_oe_o == '0)
        else $error("pin driven while crossbar disabled");
    a_uart_fixed: assert property (crossbar_global_en_i && route_a_q[0]
        |=> pin_oe_o[4] && pin_out_o[4] == $past(periph_i.uart_tx))
        else $error("UART transmit not on its fixed pin");
    a_can_fixed: assert property (crossbar_global_en_i && route_a_q[1]
        |=> pin_oe_o[6] && pin_out_o[6] == $past(periph_i.can_tx))
        else $error("CAN transmit not on its fixed pin");
    a_skip_honor: assert property (pin_skip_bits_i[0] |=> !pin_oe_o[0])
        else $error("skipped pin was driven");
    a_cmp1a_gate: assert property (slot_has[9] == route_a_q[7] || route_a_q[7])
        else $error("comparator 1 asynchronous output routed while disabled");
    a_cmp0s_gate: assert property (!route_a_q[4] |-> !slot_has[6])
        else $error("comparator 0 output routed while disabled");
    a_spi_three: assert property (route_a_q[2] && !spi_nss_4wire_i && pin_skip_bits_i == '0
        |-> slot_has[2:0] == 3'h7 && !slot_has[3])
        else $error("serial peripheral pin count wrong");
    a_cex_count: assert property ($countones(slot_en[15:11])
        == ((route_b_q[4:2] > 3'h5) ? 3'h5 : route_b_q[4:2]))
        else $error("module output count does not follow field");
    a_lsb_first: assert property (route_a_q[2] && pin_skip_bits_i == '0
        |-> slot_pin[0] == 4'h0 && slot_pin[1] == 4'h1)
        else $error("first function not on lowest pin");
    a_write_next: assert property (sfr_req_i.wr && hit_a
        |=> route_a_q == $past(sfr_req_i.wdata))
        else $error("register write not seen next cycle");

    c_uart_on: cover property (crossbar_global_en_i && route_a_q[0] ##1 pin_oe_o[4]);
    c_spi_four: cover property (slot_has[3] && crossbar_global_en_i);
    c_cex_five: cover property (route_b_q[4:2] == 3'h6);

endmodule

//--- core/pxb_defs.svh
// Constants for the port crossbar enable block: addresses, fields, resets, sizes.
`ifndef PXB_DEFS_SVH
`define PXB_DEFS_SVH

// Register addresses on the special-function register bus.
`define PXB_ADDR_ROUTE_A 8'hE1
`define PXB_ADDR_ROUTE_B 8'hE2

// Reset values of both enable registers.
`define PXB_RESET_ROUTE_A 8'h00
`define PXB_RESET_ROUTE_B 8'h00

// Bit positions in the first enable register.
`define PXB_A_CMP1_ASYNC 7
`define PXB_A_CMP1_SYNC 6
`define PXB_A_CMP0_ASYNC 5
`define PXB_A_CMP0_SYNC 4
`define PXB_A_TWOWIRE 3
`define PXB_A_SERIAL_PERIPH 2
`define PXB_A_CAN 1
`define PXB_A_UART 0

// Bit positions in the second enable register.
`define PXB_B_TIMER_B 7
`define PXB_B_TIMER_A 6
`define PXB_B_EXT_IN 5
`define PXB_B_CNT_MSB 4
`define PXB_B_CNT_LSB 2
`define PXB_B_SYSCLK 1
`define PXB_B_WRITABLE 8'hFE

// Largest number of counter-array module outputs.
`define PXB_CNT_MAX 3'h5

// Pins handled (ports 0 and 1) and routed function slots.
`define PXB_NPIN 16
`define PXB_NSLOT 19

// Fixed pins of the UART and CAN pairs.
`define PXB_PIN_UART_TX 4
`define PXB_PIN_UART_RX 5
`define PXB_PIN_CAN_TX 6
`define PXB_PIN_CAN_RX 7

// Slot indices in priority order, highest priority first.
`define PXB_S_SPI_SCK 0
`define PXB_S_SPI_MISO 1
`define PXB_S_SPI_MOSI 2
`define PXB_S_SPI_NSS 3
`define PXB_S_TW_DATA 4
`define PXB_S_TW_CLOCK 5
`define PXB_S_CMP0 6
`define PXB_S_CMP0_ASYNC 7
`define PXB_S_CMP1 8
`define PXB_S_CMP1_ASYNC 9
`define PXB_S_SYSCLK 10
`define PXB_S_MOD_OUT0 11
`define PXB_S_EXT_IN 16
`define PXB_S_TIMER_A 17
`define PXB_S_TIMER_B 18

`endif

//--- core/pxb_pkg.sv
// Types shared by the port crossbar enable block.
`include "pxb_defs.svh"

package pxb_pkg;

    // What the on-chip peripherals want to drive, one entry per routed slot.
    typedef struct packed {
        logic [`PXB_NSLOT-1:0] slot_out;
        logic [`PXB_NSLOT-1:0] slot_oe;
        logic uart_tx;
        logic can_tx;
    } pxb_periph_drive_t;

    // One special-function register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } pxb_sfr_req_t;

endpackage

//--- verif/pxb_periph_model.sv
// Model of the on-chip peripherals and of the board side of the port pins.
`timescale 1ns/1ps
`include "pxb_defs.svh"

module pxb_periph_model (
    // Controls from the bench.
    input wire logic slot_oe_i,
    input wire logic uart_tx_i,
    input wire logic [`PXB_NPIN-1:0] ext_lvl_i,
    // Crossbar pin side.
    input wire logic [`PXB_NPIN-1:0] pin_out_i,
    input wire logic [`PXB_NPIN-1:0] pin_oe_i,
    output logic [`PXB_NPIN-1:0] pin_o,
    // Crossbar peripheral side.
    output pxb_pkg::pxb_periph_drive_t periph_o
);
    // Slots drive a fixed alternating pattern; CAN sends the inverse of the UART level.
    // One assignment drives the whole bundle, so the struct has a single writer.
    assign periph_o = '{slot_out: 19'h2AAAA, slot_oe: {`PXB_NSLOT{slot_oe_i}},
                        uart_tx: uart_tx_i, can_tx: ~uart_tx_i};
    // A driven pin shows the crossbar value, so a wrong route cannot hide behind the board.
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_lvl_i);
endmodule

//--- verif/tb_port_crossbar_enables.sv
// Self-checking bench for the crossbar enable registers and the pin routing.
`timescale 1ns/1ps
`include "pxb_defs.svh"

module tb_port_crossbar_enables;
    typedef struct packed {logic [7:0] a; logic [7:0] b; logic [4:0] slot;} pxb_case_t;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    pxb_pkg::pxb_sfr_req_t req = '0;
    logic glb = 1'b0;
    logic [`PXB_NPIN-1:0] skip = '0;
    logic nss4 = 1'b0;
    logic oe = 1'b0;
    logic utx = 1'b1;
    logic [`PXB_NPIN-1:0] ext = '1;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [`PXB_NSLOT-1:0] sin;
    logic [`PXB_NSLOT-1:0] es;
    logic urx;
    logic crx;
    logic [`PXB_NPIN-1:0] pin;
    logic [`PXB_NPIN-1:0] pout;
    logic [`PXB_NPIN-1:0] poe;
    pxb_pkg::pxb_periph_drive_t drv;
    int n_fail = 0;
    int checked = 0;
    int n;
    pxb_case_t cases [9] = '{'{8'h80, 8'h00, 5'h09}, '{8'h40, 8'h00, 5'h08},
        '{8'h20, 8'h00, 5'h07}, '{8'h10, 8'h00, 5'h06}, '{8'h08, 8'h00, 5'h04},
        '{8'h00, 8'h80, 5'h12}, '{8'h00, 8'h40, 5'h11}, '{8'h00, 8'h20, 5'h10},
        '{8'h00, 8'h02, 5'h0A}};

    pxb_crossbar i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .sfr_req_i(req),
        .sfr_rdata_o(rdata), .crossbar_global_en_i(glb), .pin_skip_bits_i(skip),
        .spi_nss_4wire_i(nss4), .periph_i(drv), .slot_in_o(sin), .uart_rx_o(urx),
        .can_rx_o(crx), .pin_in_i(pin), .pin_out_o(pout), .pin_oe_o(poe));

    pxb_periph_model i_model (.slot_oe_i(oe), .uart_tx_i(utx), .ext_lvl_i(ext),
        .pin_out_i(pout), .pin_oe_i(poe), .pin_o(pin), .periph_o(drv));

    // Free-running clock at 100 MHz.
    always #5 clock_i = ~clock_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobes are held across exactly one rising edge, then dropped.
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clock_i);
        req.wr = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clock_i);
        req.rd = 1'b0;
        d = rdata;
    endtask

    // Four edges cover the one-flop pin path and the three-edge input path.
    task automatic settle();
        repeat (4) @(negedge clock_i);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hung run short well beyond the fewer than two hundred cycles the tests need.
    initial begin
        #200us;
        n_fail++;
        results();
    end

    // Main sequence.
    initial begin
        repeat (10) @(negedge clock_i);
        check(32'(poe), 32'h0);
        check(32'({urx, crx, sin}), 32'h1FFFFF);
        nrst_i = 1'b1;
        sfr_write(8'hE3, 8'hFF);
        sfr_read(8'hE3, rv);
        check(32'(rv), 32'h0);
        sfr_read(`PXB_ADDR_ROUTE_A, rv);
        check(32'(rv), 32'(`PXB_RESET_ROUTE_A));
        sfr_read(`PXB_ADDR_ROUTE_B, rv);
        check(32'(rv), 32'(`PXB_RESET_ROUTE_B));
        sfr_write(`PXB_ADDR_ROUTE_A, 8'hFF);
        sfr_write(`PXB_ADDR_ROUTE_B, 8'hFF);
        sfr_read(`PXB_ADDR_ROUTE_A, rv);
        check(32'(rv), 32'hFF);
        sfr_read(`PXB_ADDR_ROUTE_B, rv);
        check(32'(rv), 32'(`PXB_B_WRITABLE));
        // Everything selected but the global enable low: pins stay plain inputs.
        oe = 1'b1;
        ext = '0;
        settle();
        check(32'(poe), 32'h0);
        check(32'(sin), 32'h7FFFF);
        glb = 1'b1;
        oe = 1'b0;
        // One function alone lands on pin 0, which alone is pulled low.
        ext = 16'hFFFE;
        foreach (cases[i]) begin
            sfr_write(`PXB_ADDR_ROUTE_A, cases[i].a);
            sfr_write(`PXB_ADDR_ROUTE_B, cases[i].b);
            settle();
            es = ~(19'h00001 << cases[i].slot);
            check(32'(sin), 32'(es));
        end
        // Module output count, each field value below the reserved one.
        sfr_write(`PXB_ADDR_ROUTE_A, 8'h00);
        for (int v = 0; v < 7; v++) begin
            n = (v > 5) ? 5 : v;
            ext = ~((16'h0001 << n) - 16'h0001);
            sfr_write(`PXB_ADDR_ROUTE_B, 8'(v << 2));
            settle();
            es = ~(((19'h00001 << n) - 19'h00001) << 11);
            check(32'(sin), 32'(es));
        end
        // Serial peripheral takes three pins, four with its select line.
        sfr_write(`PXB_ADDR_ROUTE_B, 8'h00);
        sfr_write(`PXB_ADDR_ROUTE_A, 8'h04);
        for (int w = 0; w < 2; w++) begin
            nss4 = w[0];
            ext = w[0] ? 16'hFFF0 : 16'hFFF8;
            settle();
            check(32'(sin), w[0] ? 32'h7FFF0 : 32'h7FFF8);
        end
        // With drive enabled, only the four serial pins drive, carrying the slot levels.
        oe = 1'b1;
        settle();
        check(32'({poe, pout[3:0]}), 32'h000FA);
        // Skipped pins and the fixed UART pair push comparator 0 up to pin 6.
        // Drive stays on, so a skipped pin that still drives would show up here.
        skip = 16'h000F;
        ext = 16'hFF9F;
        sfr_write(`PXB_ADDR_ROUTE_A, 8'h11);
        settle();
        check(32'(sin), 32'h7FFBF);
        check(32'(poe), 32'h0050);
        check(32'({urx, poe[4], pout[4]}), 32'h3);
        // CAN routing appears on the second cycle after the write request.
        skip = '0;
        ext = 16'hFF7F;
        utx = 1'b0;
        sfr_write(`PXB_ADDR_ROUTE_A, 8'h00);
        settle();
        sfr_write(`PXB_ADDR_ROUTE_A, 8'h02);
        check(32'(poe[6]), 32'h0);
        @(negedge clock_i);
        check(32'({poe[6], pout[6]}), 32'h3);
        settle();
        check(32'({crx, urx}), 32'h1);
        // A second reset in mid-run clears routing and registers.
        nrst_i = 1'b0;
        @(negedge clock_i);
        check(32'({poe, crx}), 32'h1);
        nrst_i = 1'b1;
        sfr_read(`PXB_ADDR_ROUTE_A, rv);
        check(32'(rv), 32'h0);
        results();
    end
endmodule
